// ===== ptsc_pkg.sv
/*
 Constants for the synthesizer two-wire control slave: address fields, byte
 layouts, reset values and decode codes. Assumes a 20 MHz core clock.
*/
package ptsc_pkg;
    localparam logic [4:0] PTSC_ADDR_FIXED = 5'h18;
    localparam logic [1:0] PTSC_SEL_GENERAL = 2'h1;
    localparam int PTSC_CTRL_MARK_POS = 7;
    localparam int PTSC_CP_POS = 6;
    localparam int PTSC_TEST_POS = 3;
    localparam int PTSC_RSA_POS = 2;
    localparam int PTSC_RSB_POS = 1;
    localparam int PTSC_OS_POS = 0;
    localparam int PTSC_OC_POS = 4;
    localparam logic [14:0] PTSC_DIV_RESET = 15'h0000;
    localparam logic [7:0] PTSC_CTRL_RESET = 8'hc8;
    localparam logic [7:0] PTSC_PORTS_RESET = 8'h00;
    localparam logic [2:0] PTSC_TEST_NORMAL = 3'h1;
    localparam logic [2:0] PTSC_TEST_SINK = 3'h6;
    localparam logic [2:0] PTSC_TEST_SOURCE = 3'h7;
    localparam logic [2:0] PTSC_TEST_REF = 3'h4;
    localparam logic [2:0] PTSC_TEST_HALFDIV = 3'h5;
    localparam logic [2:0] PTSC_BAND_A_BITS = 3'h2;
    localparam logic [2:0] PTSC_BAND_B_BITS = 3'h4;
    localparam logic [2:0] PTSC_BAND_C_BITS = 3'h1;
    localparam logic [10:0] PTSC_REF_640 = 11'd640;
    localparam logic [10:0] PTSC_REF_1024 = 11'd1024;
    localparam logic [10:0] PTSC_REF_512 = 11'd512;

    typedef enum logic [1:0] {PTSC_BAND_OFF, PTSC_BAND_A, PTSC_BAND_B, PTSC_BAND_C}
        ptsc_band_type;
    typedef enum logic [1:0] {PTSC_PUMP_NORMAL, PTSC_PUMP_OFF, PTSC_PUMP_SINK,
        PTSC_PUMP_SOURCE} ptsc_pump_type;
    typedef enum logic [1:0] {PTSC_PTR_DIVHI, PTSC_PTR_DIVLO, PTSC_PTR_CTRL,
        PTSC_PTR_PORTS} ptsc_ptr_type;
endpackage : ptsc_pkg

// ===== ptsc_line_if.sv
/*
 Carrier of the filtered bus-line levels and edge events from the input
 conditioner to the slave. Assumes both ends share core_clk.
*/
`timescale 1ns/100ps
interface ptsc_line_if;
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport producer (output scl_level, sda_level, scl_rise, scl_fall, start_det, stop_det);
    modport consumer (input scl_level, sda_level, scl_rise, scl_fall, start_det, stop_det);
endinterface : ptsc_line_if

// ===== ptsc_line_sync.sv
/*
 Three-stage conditioner for the clock and data lines, with edge, start and
 stop detection. Assumes lines are asynchronous to core_clk.
*/
`timescale 1ns/100ps
module ptsc_line_sync
    import ptsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    ptsc_line_if.producer lines
);
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    wire scl_agree = scl_sync_reg[1] == scl_sync_reg[2];
    wire sda_agree = sda_sync_reg[1] == sda_sync_reg[2];
    wire scl_next = scl_agree ? scl_sync_reg[2] : scl_reg;
    wire sda_next = sda_agree ? sda_sync_reg[2] : sda_reg;

    // Idle bus is high, so reset to high avoids a false start
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            scl_reg <= scl_next;
            sda_reg <= sda_next;
        end
    end

    assign lines.scl_level = scl_reg;
    assign lines.sda_level = sda_reg;
    assign lines.scl_rise = scl_next & ~scl_reg;
    assign lines.scl_fall = ~scl_next & scl_reg;
    assign lines.start_det = scl_reg & scl_next & sda_reg & ~sda_next;
    assign lines.stop_det = scl_reg & scl_next & ~sda_reg & sda_next;
endmodule : ptsc_line_sync

// ===== ptsc_top.sv
/*
 Two-wire slave that programs a frequency synthesizer: divider word, control
 byte, ports byte, and a readable status byte. Assumes the analog parts
 (comparators, converter, lock detector) deliver digital levels here.
*/
// What this block does
// [RULE1] Address is 11000, two select bits, then direction bit: 0 write, 1 read.
// [RULE2] Master sends address then four data bytes to program everything.
// [RULE3] Byte pointer auto-increments within a write until STOP.
// [RULE4] First data byte top bit: 0 starts at divider high, 1 at control.
// [RULE5] Whole 15-bit divider loads on eighth clock of the low divider byte.
// [RULE6] Control register loads on eighth clock of the control byte.
// [RULE7] Ports register loads on eighth clock of the ports byte.
// [RULE8] Divider is binary 15-bit: high byte bits 14..8, low byte bits 7..0.
// [RULE9] Control byte: mark, pump current, three test, two ratio, tuning off.
// [RULE10] Test bits select normal, pump off, sink, source, or test clock output.
// [RULE11] Ratio: second bit 0 gives 640; 01 gives 1024; 11 gives 512.
// [RULE12] Tuning-off bit 1 disables the tuning output.
// [RULE13] Open-collector bits 1 turn on; bit 3 ignored; bits 2..0 band switch.
// [RULE14] Band-switch 010, 100, 001 select mixer bands A, B, C.
// [RULE15] Strap gives the select bits; select 01 always accepted too.
// [RULE16] Read address acknowledged, then status byte shifts out MSB first.
// [RULE17] Master ack asks another byte; no ack ends, device releases data.
// [RULE18] Power-on flag set at reset, cleared at end of a read.
// [RULE19] Status: power-on, lock, ports 7/5/4 levels, three converter bits.
// [RULE20] Lock flag reads 1 while the loop is locked.
// [RULE21] Master writes 0 to open-collector bits of ports used as inputs.
// [RULE22] Converter code 000..100 rises with the port 6 voltage.
// [RULE23] General select 01 accepted regardless of strap.
// [RULE24] Test clock modes route reference or half divider out on port 6.
// [RULE25] Pointer runs divider high, low, control, ports; extra bytes acked, ignored.
// [RULE26] Other band-switch codes give an inactive mixer band output.
`timescale 1ns/100ps
module ptsc_top
    import ptsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_strap_pin,
    input wire logic loop_locked_ind,
    input wire logic [2:0] port_input_levels,
    input wire logic [2:0] converter_code,
    input wire logic ref_clk_in,
    input wire logic half_div_in,
    output logic [14:0] divider_ratio_bits,
    output logic pump_current_sel,
    output logic [2:0] test_mode_bits,
    output logic [1:0] ratio_select,
    output logic [10:0] ref_divider_ratio,
    output logic [1:0] pump_mode,
    output logic tune_output_off,
    output logic tune_output_en,
    output logic [3:0] open_collector_bits,
    output logic converter_port_pin,
    output logic [2:0] band_switch_bits,
    output logic [1:0] mixer_band_out
);
    typedef enum {PTSC_IDLE, PTSC_ADDR, PTSC_ADDR_ACK, PTSC_WDATA, PTSC_WACK,
        PTSC_RDATA, PTSC_RACK} ptsc_state_type;

    ptsc_line_if lines ();

    ptsc_line_sync u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .lines(lines)
    );

    ptsc_state_type state_reg;
    ptsc_state_type state_next;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic first_byte_reg;
    logic overflow_reg;
    ptsc_ptr_type ptr_reg;
    logic [6:0] div_hi_reg;
    logic [14:0] divider_reg;
    logic [7:0] control_reg;
    logic [7:0] ports_reg;
    logic por_flag_reg;
    logic sda_oe_reg;
    logic [2:0] strap_s0_reg;
    logic [2:0] strap_s1_reg;
    logic [1:0] strap_reg;
    logic lock_sync0_reg;
    logic lock_sync1_reg;
    logic lock_reg;
    logic test_out_reg;
    logic [10:0] ref_ratio_reg;
    logic [1:0] pump_mode_reg;
    logic [1:0] band_reg;

    wire [7:0] shift_in = {shift_reg[6:0], lines.sda_level};
    wire byte_done = lines.scl_rise && bit_cnt_reg == 4'd7;
    wire [1:0] sel_bits = shift_in[2:1];
    wire addr_match = shift_in[7:3] == PTSC_ADDR_FIXED &&
        (sel_bits == strap_reg || sel_bits == PTSC_SEL_GENERAL); // [RULE1] [RULE15] [RULE23]
    wire rd_bit = shift_in[0];
    wire [7:0] status_byte = {por_flag_reg, lock_reg, port_input_levels,
        converter_code}; // [RULE19] [RULE20] [RULE22]

    // Byte landing slot: first byte chooses its slot by the top bit
    wire [1:0] slot = first_byte_reg ?
        (shift_in[7] ? PTSC_PTR_CTRL : PTSC_PTR_DIVHI) : ptr_reg; // [RULE4]
    wire wr_byte = state_reg == PTSC_WDATA && byte_done && !overflow_reg;
    wire ld_divhi = wr_byte && slot == PTSC_PTR_DIVHI;
    wire ld_divlo = wr_byte && slot == PTSC_PTR_DIVLO;
    wire ld_ctrl = wr_byte && slot == PTSC_PTR_CTRL;
    wire ld_ports = wr_byte && slot == PTSC_PTR_PORTS;
    wire read_end = state_reg == PTSC_RACK && lines.scl_rise && lines.sda_level;

    function automatic logic [10:0] ptsc_ref_ratio(input logic rsa, input logic ratio_select_second);
        if (!ratio_select_second) begin
            return PTSC_REF_640;
        end
        return rsa ? PTSC_REF_512 : PTSC_REF_1024; // [RULE11]
    endfunction : ptsc_ref_ratio

    function automatic ptsc_pump_type ptsc_pump(input logic [2:0] t);
        if (t[2:1] == 2'h1) begin
            return PTSC_PUMP_OFF;
        end
        if (t == PTSC_TEST_SINK) begin
            return PTSC_PUMP_SINK;
        end
        if (t == PTSC_TEST_SOURCE) begin
            return PTSC_PUMP_SOURCE;
        end
        return PTSC_PUMP_NORMAL; // [RULE10]
    endfunction : ptsc_pump

    wire [2:0] test_bits = control_reg[PTSC_TEST_POS +: 3];
    wire [2:0] band_bits = ports_reg[2:0];
    wire [1:0] band_next = band_bits == PTSC_BAND_A_BITS ? PTSC_BAND_A :
        band_bits == PTSC_BAND_B_BITS ? PTSC_BAND_B :
        band_bits == PTSC_BAND_C_BITS ? PTSC_BAND_C : PTSC_BAND_OFF; // [RULE14] [RULE26]
    wire test_out_next = test_bits == PTSC_TEST_REF ? ref_clk_in :
        test_bits == PTSC_TEST_HALFDIV ? half_div_in :
        ports_reg[6]; // [RULE24] [RULE13]

    always_comb begin
        state_next = state_reg;
        if (lines.start_det) begin
            state_next = PTSC_ADDR;
        end else if (lines.stop_det) begin
            state_next = PTSC_IDLE;
        end else begin
            unique case (state_reg)
                PTSC_IDLE: state_next = PTSC_IDLE;
                PTSC_ADDR: if (byte_done) begin
                    state_next = addr_match ? PTSC_ADDR_ACK : PTSC_IDLE;
                end
                // Ack slot spans the fall after bit 8 up to the fall after clock 9
                PTSC_ADDR_ACK: if (lines.scl_fall && bit_cnt_reg == 4'd9) begin
                    state_next = shift_reg[0] ? PTSC_RDATA : PTSC_WDATA; // [RULE16]
                end
                PTSC_WDATA: if (byte_done) begin
                    state_next = PTSC_WACK;
                end
                PTSC_WACK: if (lines.scl_fall && bit_cnt_reg == 4'd9) begin
                    state_next = PTSC_WDATA; // [RULE3]
                end
                PTSC_RDATA: if (lines.scl_fall && bit_cnt_reg == 4'd7) begin
                    state_next = PTSC_RACK;
                end
                // Next byte starts on the fall, so data never moves while SCL is high
                PTSC_RACK: if (lines.scl_rise && lines.sda_level) begin
                    state_next = PTSC_IDLE; // [RULE17]
                end else if (lines.scl_fall) begin
                    state_next = PTSC_RDATA;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= PTSC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bit counter and shifter; reads preload the status byte
    always_ff @(posedge core_clk) begin
        if (srst || lines.start_det) begin
            bit_cnt_reg <= 4'd0;
            shift_reg <= 8'h00;
        end else if (state_next == PTSC_RDATA && state_reg != PTSC_RDATA) begin
            bit_cnt_reg <= 4'd0;
            shift_reg <= status_byte;
        end else if (state_reg == PTSC_RDATA && lines.scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            shift_reg <= {shift_reg[6:0], 1'b0}; // [RULE16]
        end else if ((state_reg == PTSC_ADDR || state_reg == PTSC_WDATA) &&
                lines.scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            shift_reg <= shift_in;
        end else if ((state_reg == PTSC_WACK || state_reg == PTSC_ADDR_ACK) &&
                lines.scl_fall) begin
            bit_cnt_reg <= (bit_cnt_reg == 4'd8) ? 4'd9 : 4'd0;
        end
    end

    // Write byte pointer with its first-byte flag and overflow stop
    always_ff @(posedge core_clk) begin
        if (srst || lines.start_det) begin
            first_byte_reg <= 1'b1;
            overflow_reg <= 1'b0;
            ptr_reg <= PTSC_PTR_DIVHI;
        end else if (wr_byte) begin
            first_byte_reg <= 1'b0;
            ptr_reg <= ptsc_ptr_type'(slot + 2'd1); // [RULE3] [RULE25]
            overflow_reg <= slot == PTSC_PTR_PORTS; // [RULE25]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            div_hi_reg <= PTSC_DIV_RESET[14:8];
            divider_reg <= PTSC_DIV_RESET;
            control_reg <= PTSC_CTRL_RESET;
            ports_reg <= PTSC_PORTS_RESET;
        end else begin
            if (ld_divhi) begin
                div_hi_reg <= shift_in[6:0]; // [RULE8]
            end
            if (ld_divlo) begin
                divider_reg <= {div_hi_reg, shift_in}; // [RULE5] [RULE8]
            end
            if (ld_ctrl) begin
                control_reg <= shift_in; // [RULE6] [RULE9]
            end
            if (ld_ports) begin
                ports_reg <= shift_in; // [RULE7]
            end
        end
    end

    // Power-on flag: only a read ended by a missing master ack clears it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            por_flag_reg <= 1'b1;
        end else if (read_end) begin
            por_flag_reg <= 1'b0; // [RULE18]
        end
    end

    // Data line drive: ack low after matched address and each write byte
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sda_oe_reg <= 1'b0;
        end else begin
            unique case (state_next)
                // Pull low only once SCL has fallen after bit 8
                PTSC_ADDR_ACK, PTSC_WACK: sda_oe_reg <= lines.scl_fall | sda_oe_reg;
                PTSC_RDATA: sda_oe_reg <= lines.scl_fall || state_reg != PTSC_RDATA ?
                    ~(state_reg == PTSC_RDATA ? shift_reg[6] : status_byte[7]) :
                    sda_oe_reg;
                default: sda_oe_reg <= 1'b0; // [RULE17]
            endcase
        end
    end

    // Strap and lock come from outside the clock: three stages for strap, two for lock, two agreeing
    always_ff @(posedge core_clk) begin
        if (srst) begin
            strap_s0_reg <= 3'h0;
            strap_s1_reg <= 3'h0;
            strap_reg <= 2'h0;
            lock_sync0_reg <= 1'b0;
            lock_sync1_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            strap_s0_reg <= {strap_s0_reg[1:0], addr_strap_pin[0]};
            strap_s1_reg <= {strap_s1_reg[1:0], addr_strap_pin[1]};
            if (strap_s0_reg[1] == strap_s0_reg[2] && strap_s1_reg[1] == strap_s1_reg[2]) begin
                strap_reg <= {strap_s1_reg[2], strap_s0_reg[2]}; // [RULE15]
            end
            lock_sync0_reg <= loop_locked_ind;
            lock_sync1_reg <= lock_sync0_reg;
            if (lock_sync1_reg == lock_sync0_reg) begin
                lock_reg <= lock_sync1_reg; // [RULE20]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            test_out_reg <= 1'b0;
            ref_ratio_reg <= PTSC_REF_640;
            pump_mode_reg <= PTSC_PUMP_NORMAL;
            band_reg <= PTSC_BAND_OFF;
        end else begin
            test_out_reg <= test_out_next;
            ref_ratio_reg <= ptsc_ref_ratio(control_reg[PTSC_RSA_POS], control_reg[PTSC_RSB_POS]);
            pump_mode_reg <= ptsc_pump(test_bits);
            band_reg <= band_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign divider_ratio_bits = divider_reg;
    assign pump_current_sel = control_reg[PTSC_CP_POS]; // [RULE9]
    assign test_mode_bits = test_bits;
    assign ratio_select = control_reg[PTSC_RSA_POS -: 2];
    assign ref_divider_ratio = ref_ratio_reg;
    assign pump_mode = pump_mode_reg;
    assign tune_output_off = control_reg[PTSC_OS_POS];
    assign tune_output_en = ~control_reg[PTSC_OS_POS]; // [RULE12]
    assign open_collector_bits = ports_reg[PTSC_OC_POS +: 4]; // [RULE13] [RULE21]
    assign converter_port_pin = test_out_reg;
    assign band_switch_bits = ports_reg[2:0];
    assign mixer_band_out = band_reg;
endmodule : ptsc_top

// ===== ptsc_master.sv
/*
 Two-wire bus master model: start, stop and nine-slot byte tasks.
 Assumes the bench forms a pulled-up SDA wire from sda_low and the slave enable.
*/
`timescale 1ns/100ps
module ptsc_master (
    input wire logic core_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    // A quarter bit of 10 cycles outlasts the slave's input filter delay
    localparam int QTR = 10;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick();
        repeat (QTR) @(posedge core_clk);
        #2;
    endtask : tick
    task automatic start();
        sda_low = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b0;
        tick();
    endtask : stop
    // A 1 in the ninth slot releases the line so the slave may answer
    task automatic xbyte(input logic [7:0] d, input logic a_in, output logic [7:0] q,
            output logic a_out);
        logic [8:0] w;
        logic [8:0] r;
        w = {d, a_in};
        for (int i = 8; i >= 0; i--) begin
            sda_low = !w[i];
            tick();
            scl = 1'b1;
            tick();
            r[i] = sda_line;
            tick();
            scl = 1'b0;
            tick();
        end
        q = r[8:1];
        a_out = r[0];
    endtask : xbyte
endmodule : ptsc_master

// ===== ptsc_top_sva.sv
/*
 Checker for the synthesizer control slave, seeing only its top ports.
 Assumes decoded outputs follow their source registers by one cycle.
*/
`timescale 1ns/100ps
module ptsc_top_sva
    import ptsc_pkg::*;
(
    input logic core_clk,
    input logic srst,
    input logic scl_in,
    input logic sda_out,
    input logic sda_oe,
    input logic ref_clk_in,
    input logic half_div_in,
    input logic [14:0] divider_ratio_bits,
    input logic [2:0] test_mode_bits,
    input logic [1:0] ratio_select,
    input logic [10:0] ref_divider_ratio,
    input logic [1:0] pump_mode,
    input logic tune_output_off,
    input logic tune_output_en,
    input logic [3:0] open_collector_bits,
    input logic converter_port_pin,
    input logic [2:0] band_switch_bits,
    input logic [1:0] mixer_band_out
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    function automatic logic [1:0] pump_of(input logic [2:0] t);
        return (t[2:1] == 2'h1) ? PTSC_PUMP_OFF : (t == PTSC_TEST_SINK) ? PTSC_PUMP_SINK
            : (t == PTSC_TEST_SOURCE) ? PTSC_PUMP_SOURCE : PTSC_PUMP_NORMAL;
    endfunction : pump_of
    function automatic logic [1:0] band_of(input logic [2:0] b);
        return (b == PTSC_BAND_A_BITS) ? PTSC_BAND_A : (b == PTSC_BAND_B_BITS) ? PTSC_BAND_B
            : (b == PTSC_BAND_C_BITS) ? PTSC_BAND_C : PTSC_BAND_OFF;
    endfunction : band_of
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("sda enable rose with scl high");
    a_release_scl_low: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("sda enable fell with scl high");
    a_drive_low_only: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("sda driven high");
    a_ratio_decode: assert property (!$past(srst) |-> ref_divider_ratio ==
        (!$past(ratio_select[0]) ? PTSC_REF_640 : $past(ratio_select[1]) ? PTSC_REF_512
        : PTSC_REF_1024)) else $error("reference ratio decode wrong");
    a_pump_decode: assert property (!$past(srst) |->
        pump_mode == pump_of($past(test_mode_bits))) else $error("pump mode decode wrong");
    a_band_decode: assert property (!$past(srst) |->
        mixer_band_out == band_of($past(band_switch_bits))) else $error("band decode wrong");
    a_tune_enable: assert property (tune_output_en != tune_output_off)
        else $error("tuning enable not inverse of off bit");
    a_port6_route: assert property (!$past(srst) |-> converter_port_pin ==
        (($past(test_mode_bits) == PTSC_TEST_REF) ? $past(ref_clk_in)
        : ($past(test_mode_bits) == PTSC_TEST_HALFDIV) ? $past(half_div_in)
        : $past(open_collector_bits[2]))) else $error("port 6 source wrong");
    a_load_scl_high: assert property (!$stable({divider_ratio_bits, test_mode_bits,
        band_switch_bits}) |-> scl_in) else $error("register loaded with scl low");
    c_ack: cover property ($rose(sda_oe));
    c_ratio_512: cover property (ref_divider_ratio == PTSC_REF_512);
    c_band_c: cover property (mixer_band_out == PTSC_BAND_C);
endmodule : ptsc_top_sva

bind ptsc_top ptsc_top_sva u_sva (.core_clk(core_clk), .srst(srst), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .ref_clk_in(ref_clk_in), .half_div_in(half_div_in),
    .divider_ratio_bits(divider_ratio_bits), .test_mode_bits(test_mode_bits),
    .ratio_select(ratio_select), .ref_divider_ratio(ref_divider_ratio), .pump_mode(pump_mode),
    .tune_output_off(tune_output_off), .tune_output_en(tune_output_en),
    .open_collector_bits(open_collector_bits), .converter_port_pin(converter_port_pin),
    .band_switch_bits(band_switch_bits), .mixer_band_out(mixer_band_out));

// ===== ptsc_top_tb.sv
/*
 Self-checking bench for the synthesizer control slave with a bus master model.
 Assumes a 20 MHz core clock and a pulled-up SDA wire.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module ptsc_top_tb
    import ptsc_pkg::*;
();
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] strap = 2'h0;
    logic lock = 1'b0;
    logic [2:0] inlv = 3'h0;
    logic [2:0] conv = 3'h0;
    logic scl, sda_low, sda_out, sda_oe, pcs, tof, ten, ppin;
    logic [14:0] div;
    logic [2:0] tmb, band;
    logic [1:0] rsel, pmode, mix;
    logic [10:0] rref;
    logic [3:0] ocb;
    int bad_count = 0;
    int check_count = 0;
    int nak;
    logic [7:0] st;
    wire logic sda_line = !(sda_low | sda_oe);
    ptsc_master m (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    ptsc_top dut (.core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pin(strap), .loop_locked_ind(lock),
        .port_input_levels(inlv), .converter_code(conv), .ref_clk_in(1'b1),
        .half_div_in(1'b0), .divider_ratio_bits(div), .pump_current_sel(pcs),
        .test_mode_bits(tmb), .ratio_select(rsel), .ref_divider_ratio(rref),
        .pump_mode(pmode), .tune_output_off(tof), .tune_output_en(ten),
        .open_collector_bits(ocb), .converter_port_pin(ppin), .band_switch_bits(band),
        .mixer_band_out(mix));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [1:0] sel, input logic [7:0] b[$], output int n);
        logic [7:0] q;
        logic a;
        m.start();
        m.xbyte({PTSC_ADDR_FIXED, sel, 1'b0}, 1'b1, q, a);
        n = int'(a);
        foreach (b[i]) begin
            if (n == 0) begin
                m.xbyte(b[i], 1'b1, q, a);
                n += int'(a);
            end
        end
        m.stop();
    endtask : wr
    task automatic rd(input int cnt, output logic [7:0] s);
        logic [7:0] q;
        logic a;
        m.start();
        m.xbyte({PTSC_ADDR_FIXED, PTSC_SEL_GENERAL, 1'b1}, 1'b1, q, a);
        `CHK("read ack", 1'b0, a)
        for (int i = 0; i < cnt; i++) begin
            m.xbyte(8'hff, i == cnt - 1, q, a);
            if (i == 0) begin
                s = q;
            end
        end
        m.stop();
    endtask : rd
    task automatic s_reset();
        `CHK("divider", 15'h0000, div)
        `CHK("ref ratio", PTSC_REF_640, rref)
        `CHK("pump", PTSC_PUMP_NORMAL, pmode)
        `CHK("ports", 4'h0, ocb)
        `CHK("sda_oe", 1'b0, sda_oe)
    endtask : s_reset
    task automatic s_full();
        wr(2'h1, '{8'h2a, 8'h5c, 8'hca, 8'hea, 8'h55}, nak);
        `CHK("nak", 0, nak)
        `CHK("divider", 15'h2a5c, div)
        `CHK("pump current", 1'b1, pcs)
        `CHK("ref ratio", PTSC_REF_1024, rref)
        `CHK("tune en", 1'b1, ten)
        `CHK("ports", 4'he, ocb)
        `CHK("mixer", PTSC_BAND_A, mix)
        `CHK("port6", 1'b1, ppin)
    endtask : s_full
    task automatic s_pair();
        wr(2'h1, '{8'h11}, nak);
        `CHK("divider held", 15'h2a5c, div)
        wr(2'h1, '{8'h11, 8'h22}, nak);
        `CHK("divider", 15'h1122, div)
    endtask : s_pair
    task automatic s_ctrl();
        for (int t = 0; t < 8; t++) begin
            wr(2'h1, '{{2'h2, 3'(t), t[1], t[0], t[2]}}, nak);
            `CHK("test bits", 3'(t), tmb)
            `CHK("pump", (t[2:1] == 2'h1) ? PTSC_PUMP_OFF : (t == 6) ? PTSC_PUMP_SINK
                : (t == 7) ? PTSC_PUMP_SOURCE : PTSC_PUMP_NORMAL, pmode)
            `CHK("ref", !t[0] ? PTSC_REF_640 : t[1] ? PTSC_REF_512 : PTSC_REF_1024, rref)
            `CHK("tune off", t[2], tof)
            `CHK("port6", (t == 5) ? 1'b0 : 1'b1, ppin)
            `CHK("band kept", 3'h2, band)
        end
    endtask : s_ctrl
    task automatic s_band();
        for (int b = 0; b < 8; b++) begin
            wr(2'h1, '{8'hc8, {5'h01, 3'(b)}}, nak);
            `CHK("band", 3'(b), band)
            `CHK("mixer", (b == 2) ? PTSC_BAND_A : (b == 4) ? PTSC_BAND_B
                : (b == 1) ? PTSC_BAND_C : PTSC_BAND_OFF, mix)
            `CHK("ports", 4'h0, ocb)
        end
    endtask : s_band
    task automatic s_addr();
        strap = 2'h2;
        wr(2'h3, '{8'hcf}, nak);
        `CHK("refused", 1, nak)
        `CHK("test kept", 3'h1, tmb)
        wr(2'h2, '{8'h8b}, nak);
        `CHK("strap nak", 0, nak)
        `CHK("ratio sel", 2'h1, rsel)
        `CHK("tune off", 1'b1, tof)
    endtask : s_addr
    task automatic s_read();
        lock = 1'b1;
        inlv = 3'h5;
        conv = 3'h4;
        rd(2, st);
        `CHK("status", 8'hec, st)
        `CHK("released", 1'b0, sda_oe)
        lock = 1'b0;
        inlv = 3'h2;
        conv = 3'h3;
        rd(1, st);
        `CHK("status", 8'h13, st)
    endtask : s_read
    initial begin
        repeat (90000) @(posedge core_clk);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        #2;
        srst = 1'b0;
        repeat (8) @(posedge core_clk);
        s_reset();
        s_full();
        s_pair();
        s_ctrl();
        s_band();
        s_addr();
        s_read();
        conclude();
    end
endmodule : ptsc_top_tb
